// File: design/dcf_debug_regs.sv
// Purpose: Debug control and flag registers between the TAP and the CPU.
// Assumes: sys_rst is the power-on reset; tap_tlr marks Test-Logic-Reset.
// Notes: TAP-side state runs on tck; all crossings are synchronised.
`timescale 1ns/1ps
// Contract
// - The register-break enable bit always reads zero.
// - The timer enable bit reads zero and the timer halts in debug mode.
// - With debug mode enable clear, commands work but breakpoints are off.
// - With debug mode enable set, breakpoint matches request a break.
// - Debug mode enable changes only by writes made in background mode.
// - The flag register clears on power-on reset and Test-Logic-Reset.
// - All flag bits read back, and only bit 0 takes CPU writes.
// - The end of each TAP transfer sets the transfer-complete flag.
// - Any CPU write to the flag bit clears the programming source select.
// - The CPU reads program enable as local bit OR the JTAG buffer bit.
// - After reset, merged program enable 1 boots ROM, 0 boots user code.
// - Program enable is read-only; its local bit clears only on the two resets.
// - The JTAG program enable clears once ROM-operation-done is set.
// - Command codes 4 to 9 decode to their debug operations.
// - The holding buffer carries data between host and debug code.
module dcf_debug_regs (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input dcf_pkg::dcf_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic bg_mode,
   input wire logic bp_match,
   input wire logic rom_done,
   input wire logic spe_set,
   output logic bp_enable,
   output logic break_req,
   output logic timer_halt,
   output dcf_pkg::dcf_cmd_t dbg_cmd,
   output logic [7:0] hold_buf,
   output logic boot_valid,
   output logic boot_rom,
   input wire logic tck,
   input wire logic tap_tlr,
   input wire logic tap_xfer_done,
   input dcf_pkg::dcf_spb_req_t spb_req,
   output logic spb_spe,
   output logic [1:0] spb_pss
);
   dcf_pkg::dcf_sys_st_t s_q;
   dcf_pkg::dcf_sys_st_t s_d;
   dcf_pkg::dcf_tck_st_t t_q;
   dcf_pkg::dcf_tck_st_t t_d;
   logic x_ev;
   logic flag_wr;
   logic ctrl_wr;
   logic spe_rd;
   logic t_rst;
   logic p_ev;
   logic rod_ev;

   // ***************************************************
   // CPU clock domain
   // ***************************************************
   assign x_ev = (s_q.xs[1] == s_q.xs[2]) && (s_q.xs[2] != s_q.xacc);
   assign flag_wr = sfr_req.wr && sfr_req.addr == dcf_pkg::DCF_ADDR_FLAG;
   assign ctrl_wr = sfr_req.wr && sfr_req.addr == dcf_pkg::DCF_ADDR_CTRL;
   assign spe_rd = s_q.system_program_enable | s_q.spb_m;

   always_comb begin
      s_d = s_q;
      s_d.xs = {s_q.xs[1:0], t_q.xtog};
      s_d.ts = {s_q.ts[1:0], tap_tlr};
      s_d.ss = {s_q.ss[1:0], t_q.system_program_enable};
      if (s_q.ts[1] == s_q.ts[2]) begin
         s_d.tlr_m = s_q.ts[2];
      end
      if (s_q.ss[1] == s_q.ss[2]) begin
         s_d.spb_m = s_q.ss[2];
      end
      if (x_ev) begin
         s_d.xacc = s_q.xs[2];
      end
      if (flag_wr) begin
         s_d.transfer_complete_flag = sfr_req.wdata[dcf_pkg::DCF_FLAG_TXC];
         s_d.pss_tog = ~s_q.pss_tog;
      end
      if (x_ev) begin
         s_d.transfer_complete_flag = 1'b1;
      end
      if (spe_set) begin
         s_d.system_program_enable = 1'b1;
      end
      if (sfr_req.wr && sfr_req.addr == dcf_pkg::DCF_ADDR_BUF) begin
         s_d.hbuf = sfr_req.wdata;
      end
      if (ctrl_wr) begin
         s_d.cmd = sfr_req.wdata[3:0];
         if (bg_mode) begin
            s_d.debug_mode_enable = sfr_req.wdata[dcf_pkg::DCF_CTRL_DME];
         end
      end
      unique case (s_q.cmd)
         4'h4: s_d.cmd_o = dcf_pkg::DCF_CMD_WREG;
         4'h5: s_d.cmd_o = dcf_pkg::DCF_CMD_WDATA;
         4'h6: s_d.cmd_o = dcf_pkg::DCF_CMD_STEP;
         4'h7: s_d.cmd_o = dcf_pkg::DCF_CMD_RET;
         4'h8: s_d.cmd_o = dcf_pkg::DCF_CMD_UNLK;
         4'h9: s_d.cmd_o = dcf_pkg::DCF_CMD_RREG;
         default: s_d.cmd_o = dcf_pkg::DCF_CMD_NOP;
      endcase
      s_d.bp_en = s_q.debug_mode_enable;
      s_d.brk = s_q.debug_mode_enable & bp_match;
      s_d.thalt = bg_mode;
      unique case (sfr_req.addr)
         dcf_pkg::DCF_ADDR_FLAG: s_d.rdata = {6'h00, spe_rd, s_q.transfer_complete_flag};
         dcf_pkg::DCF_ADDR_CTRL: s_d.rdata = {s_q.debug_mode_enable, 3'h0, s_q.cmd};
         dcf_pkg::DCF_ADDR_BUF: s_d.rdata = s_q.hbuf;
         default: s_d.rdata = 8'h00;
      endcase
      if (!s_q.boot_valid) begin
         if (s_q.boot_cnt == dcf_pkg::DCF_BOOT_WAIT) begin
            s_d.boot_valid = 1'b1;
            s_d.boot_rom = spe_rd;
         end else begin
            s_d.boot_cnt = s_q.boot_cnt + 3'h1;
         end
      end
      if (s_q.tlr_m) begin
         s_d.transfer_complete_flag = 1'b0;
         s_d.system_program_enable = 1'b0;
         s_d.hbuf = dcf_pkg::DCF_BUF_RST;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.transfer_complete_flag <= dcf_pkg::DCF_FLAG_RST[0];
         s_q.system_program_enable <= dcf_pkg::DCF_FLAG_RST[1];
         s_q.cmd <= dcf_pkg::DCF_CMD_RST;
         s_q.cmd_o <= dcf_pkg::DCF_CMD_NOP;
         s_q.hbuf <= dcf_pkg::DCF_BUF_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign sfr_rdata = s_q.rdata;
   assign bp_enable = s_q.bp_en;
   assign break_req = s_q.brk;
   assign timer_halt = s_q.thalt;
   assign dbg_cmd = s_q.cmd_o;
   assign hold_buf = s_q.hbuf;
   assign boot_valid = s_q.boot_valid;
   assign boot_rom = s_q.boot_rom;

   // ***************************************************
   // TAP clock domain
   // ***************************************************
   assign t_rst = tap_tlr | (t_q.rs[1] & t_q.rs[2]);
   assign p_ev = (t_q.ps[1] == t_q.ps[2]) && (t_q.ps[2] != t_q.pacc);
   assign rod_ev = (t_q.rd[1] == t_q.rd[2]) && t_q.rd[2] && !t_q.rod_m;

   always_comb begin
      t_d = t_q;
      t_d.rs = {t_q.rs[1:0], sys_rst};
      t_d.ps = {t_q.ps[1:0], s_q.pss_tog};
      t_d.rd = {t_q.rd[1:0], rom_done};
      if (t_q.rd[1] == t_q.rd[2]) begin
         t_d.rod_m = t_q.rd[2];
      end
      if (p_ev) begin
         t_d.pacc = t_q.ps[2];
      end
      if (tap_xfer_done) begin
         t_d.xtog = ~t_q.xtog;
      end
      if (spb_req.wr) begin
         t_d.system_program_enable = spb_req.system_program_enable;
         t_d.pss = spb_req.pss;
      end
      if (p_ev) begin
         t_d.pss = 2'h0;
      end
      if (rod_ev) begin
         t_d.system_program_enable = 1'b0;
      end
      if (t_rst) begin
         t_d.system_program_enable = 1'b0;
         t_d.pss = 2'h0;
      end
      // Power-on reset also settles the crossing state on this side.
      // Test-Logic-Reset alone leaves the transfer toggle alone, so that
      // the CPU side does not see a false end of transfer afterwards.
      if (t_q.rs[1] & t_q.rs[2]) begin
         t_d.xtog = 1'b0;
         t_d.ps = 3'h0;
         t_d.pacc = 1'b0;
         t_d.rd = 3'h0;
         t_d.rod_m = 1'b0;
      end
   end

   always_ff @(posedge tck) begin
      t_q <= t_d;
   end

   assign spb_spe = t_q.system_program_enable;
   assign spb_pss = t_q.pss;

   // ***************************************************
   // Checks
   // ***************************************************
   register_break_enable_reads_zero_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      sfr_req.addr == dcf_pkg::DCF_ADDR_CTRL |=> sfr_rdata[5:4] == 2'h0)
      else $error("Break enable bit read back non-zero.");
   timer_halt_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      bg_mode ##1 bg_mode |-> timer_halt && !sfr_rdata[6])
      else $error("Timer not halted in debug mode.");
   bp_off_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !s_q.debug_mode_enable |=> !break_req && !bp_enable)
      else $error("Breakpoint active with debug mode off.");
   bp_on_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_q.debug_mode_enable && bp_match |=> break_req)
      else $error("Breakpoint match lost with debug mode on.");
   dme_user_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !bg_mode |=> $stable(s_q.debug_mode_enable))
      else $error("Debug mode enable changed outside background mode.");
   tlr_clear_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      s_q.tlr_m |=> !s_q.transfer_complete_flag && !s_q.system_program_enable)
      else $error("Flags not cleared in Test-Logic-Reset.");
   flag_reserved_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      sfr_req.addr == dcf_pkg::DCF_ADDR_FLAG |=> sfr_rdata[7:2] == 6'h00)
      else $error("Reserved flag bits read non-zero.");
   txc_set_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      x_ev && !s_q.tlr_m |=> s_q.transfer_complete_flag)
      else $error("Transfer end did not set the flag.");
   spe_merge_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      sfr_req.addr == dcf_pkg::DCF_ADDR_FLAG |=> sfr_rdata[1] == $past(spe_rd))
      else $error("Program enable read is not the merged value.");
   boot_pick_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(boot_valid) |-> boot_rom == $past(spe_rd))
      else $error("Boot choice does not follow program enable.");
   pss_clear_a: assert property (
      @(posedge tck) disable iff (t_rst)
      p_ev |=> spb_pss == 2'h0)
      else $error("Source select not cleared by flag write.");
   rod_clear_a: assert property (
      @(posedge tck) disable iff (t_rst)
      rod_ev |=> !spb_spe)
      else $error("JTAG program enable survived operation done.");

   txc_seen_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      x_ev ##1 flag_wr);
   break_seen_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      break_req);
   boot_rom_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
      $rose(boot_valid) && boot_rom);
endmodule // dcf_debug_regs

// File: design/dcf_pkg.sv
// Purpose: Shared constants and types for the debug control and flag block.
// Assumes: An 8-bit special-function register port on the CPU side.
// Notes: Offsets are SFR addresses.
package dcf_pkg;
   localparam logic [7:0] DCF_ADDR_CTRL = 8'h19;
   localparam logic [7:0] DCF_ADDR_FLAG = 8'h1B;
   localparam logic [7:0] DCF_ADDR_BUF = 8'h1C;
   localparam int DCF_FLAG_TXC = 0;
   localparam int DCF_FLAG_SPE = 1;
   localparam int DCF_CTRL_REGISTER_BREAK_ENABLE = 5;
   localparam int DCF_CTRL_TE = 6;
   localparam int DCF_CTRL_DME = 7;
   localparam logic [7:0] DCF_FLAG_RST = 8'h00;
   localparam logic [7:0] DCF_BUF_RST = 8'h00;
   localparam logic [3:0] DCF_CMD_RST = 4'hF;
   localparam logic [2:0] DCF_BOOT_WAIT = 3'h6;

   typedef enum logic [3:0] {
      DCF_CMD_WREG = 4'h4,
      DCF_CMD_WDATA = 4'h5,
      DCF_CMD_STEP = 4'h6,
      DCF_CMD_RET = 4'h7,
      DCF_CMD_UNLK = 4'h8,
      DCF_CMD_RREG = 4'h9,
      DCF_CMD_NOP = 4'hF
   } dcf_cmd_t;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dcf_sfr_req_t;

   typedef struct packed {
      logic wr;
      logic system_program_enable;
      logic [1:0] pss;
   } dcf_spb_req_t;

   typedef struct packed {
      logic transfer_complete_flag;
      logic system_program_enable;
      logic debug_mode_enable;
      logic [3:0] cmd;
      dcf_cmd_t cmd_o;
      logic [7:0] hbuf;
      logic [7:0] rdata;
      logic bp_en;
      logic brk;
      logic thalt;
      logic [2:0] boot_cnt;
      logic boot_valid;
      logic boot_rom;
      logic [2:0] xs;
      logic xacc;
      logic [2:0] ts;
      logic tlr_m;
      logic [2:0] ss;
      logic spb_m;
      logic pss_tog;
   } dcf_sys_st_t;

   typedef struct packed {
      logic [2:0] rs;
      logic system_program_enable;
      logic [1:0] pss;
      logic xtog;
      logic [2:0] ps;
      logic pacc;
      logic [2:0] rd;
      logic rod_m;
   } dcf_tck_st_t;
endpackage : dcf_pkg

// File: testbench/dcf_jtag_host.sv
// Purpose: JTAG host model that drives the TAP side of the debug block.
// Assumes: tck is made by the bench and runs for the whole test.
// Notes: Every request changes just after a rising tck edge.
`timescale 1ns/1ps
module dcf_jtag_host (
   input wire logic tck,
   output logic tap_tlr,
   output logic tap_xfer_done,
   output dcf_pkg::dcf_spb_req_t spb_req
);
   initial begin
      tap_tlr = 1'b0;
      tap_xfer_done = 1'b0;
      spb_req = '0;
   end

   // The end of one serial transfer, seen as a one-cycle pulse.
   task automatic pulse_xfer();
      @(posedge tck) #1 tap_xfer_done = 1'b1;
      @(posedge tck) #1 tap_xfer_done = 1'b0;
   endtask

   // Released buffer data is inverted so that stale values cannot match.
   task automatic spb_write(input logic system_program_enable, input logic [1:0] pss);
      @(posedge tck) #1 spb_req = '{wr: 1'b1, system_program_enable: system_program_enable, pss: pss};
      @(posedge tck) #1 spb_req = '{wr: 1'b0, system_program_enable: ~system_program_enable, pss: ~pss};
   endtask

   task automatic test_reset();
      @(posedge tck) #1 tap_tlr = 1'b1;
      repeat (4) @(posedge tck);
      #1 tap_tlr = 1'b0;
   endtask
endmodule // dcf_jtag_host

// File: testbench/debug_control_and_flag_regs_bench.sv
// Purpose: Self-checking bench for the debug control and flag registers.
// Assumes: CPU-side inputs change at the falling edge of sys_clk; TAP inputs change just after a rising tck edge.
// Notes: Seed 85; a cycle ceiling cuts a hang short.
`timescale 1ns/1ps
module debug_control_and_flag_regs_bench;
   localparam logic [7:0] FLAG = dcf_pkg::DCF_ADDR_FLAG;
   localparam logic [7:0] CTRL = dcf_pkg::DCF_ADDR_CTRL;
   localparam logic [7:0] BUF = dcf_pkg::DCF_ADDR_BUF;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic tck = 1'b0;
   logic bg_mode, bp_match, rom_done, spe_set, tap_tlr, tap_xfer_done;
   logic bp_enable, break_req, timer_halt, boot_valid, boot_rom, spb_spe;
   logic [7:0] sfr_rdata, hold_buf;
   logic [1:0] spb_pss;
   dcf_pkg::dcf_sfr_req_t sfr_req;
   dcf_pkg::dcf_spb_req_t spb_req;
   dcf_pkg::dcf_cmd_t dbg_cmd;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   dcf_debug_regs dcf_debug_regs_inst (.sys_clk, .sys_rst, .sfr_req,
      .sfr_rdata, .bg_mode, .bp_match, .rom_done, .spe_set, .bp_enable,
      .break_req, .timer_halt, .dbg_cmd, .hold_buf, .boot_valid, .boot_rom,
      .tck, .tap_tlr, .tap_xfer_done, .spb_req, .spb_spe, .spb_pss);
   dcf_jtag_host dcf_jtag_host_inst (.tck, .tap_tlr, .tap_xfer_done,
      .spb_req);

   always #25 sys_clk = ~sys_clk;
   initial begin
      #7;
      forever #15 tck = ~tck;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk) sfr_req = '{wr: 1'b1, addr: a, wdata: d};
      @(negedge sys_clk) sfr_req.wr = 1'b0;
   endtask
   // Rereads a register until the masked value matches, then compares.
   task automatic poll(input logic [7:0] a, input logic [7:0] m,
                       input logic [7:0] e);
      logic [7:0] d;
      for (int i = 0; i < 20; i++) begin
         @(negedge sys_clk) sfr_req = '{wr: 1'b0, addr: a, wdata: 8'h00};
         @(negedge sys_clk) d = sfr_rdata & m;
         if (d === e) break;
      end
      chk(d, e);
   endtask
   function automatic logic [7:0] exp_cmd(input logic [3:0] c);
      return (c >= 4'h4 && c <= 4'h9) ? {4'h0, c} : 8'h0F;
   endfunction
   task automatic conclude();
      $display("Errors %0d, comparisons %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         conclude();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [7:0] v;
      sfr_req = '0;
      {bg_mode, bp_match, rom_done, spe_set} = 4'h0;
      void'($urandom(85));
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk({6'h00, boot_valid, boot_rom}, 8'h02);
      poll(FLAG, 8'hFF, 8'h00);
      poll(8'h3A, 8'hFF, 8'h00);
      wr(FLAG, 8'hFF);
      poll(FLAG, 8'hFF, 8'h01);
      wr(FLAG, 8'hFE);
      poll(FLAG, 8'hFF, 8'h00);
      dcf_jtag_host_inst.pulse_xfer();
      poll(FLAG, 8'hFF, 8'h01);
      wr(FLAG, 8'h00);
      poll(FLAG, 8'hFF, 8'h00);
      repeat (4) @(negedge sys_clk);
      dcf_jtag_host_inst.spb_write(1'b1, 2'h3);
      poll(FLAG, 8'hFF, 8'h02);
      chk({6'h00, spb_pss}, 8'h03);
      wr(FLAG, 8'h00);
      for (int i = 0; i < 30 && spb_pss !== 2'h0; i++) @(negedge sys_clk);
      chk({6'h00, spb_pss}, 8'h00);
      poll(FLAG, 8'hFF, 8'h02);
      rom_done = 1'b1;
      for (int i = 0; i < 30 && spb_spe !== 1'b0; i++) @(negedge sys_clk);
      chk({7'h00, spb_spe}, 8'h00);
      rom_done = 1'b0;
      poll(FLAG, 8'hFF, 8'h00);
      @(negedge sys_clk) spe_set = 1'b1;
      @(negedge sys_clk) spe_set = 1'b0;
      poll(FLAG, 8'hFF, 8'h02);
      dcf_jtag_host_inst.test_reset();
      poll(FLAG, 8'hFF, 8'h00);
      v = 8'($urandom);
      repeat (4) @(negedge sys_clk);
      wr(BUF, v);
      poll(BUF, 8'hFF, v);
      chk(hold_buf, v);
      wr(CTRL, 8'h80);
      poll(CTRL, 8'hF0, 8'h00);
      bg_mode = 1'b1;
      wr(CTRL, 8'h80 | (8'($urandom) & 8'h70));
      poll(CTRL, 8'hF0, 8'h80);
      chk({6'h00, bp_enable, timer_halt}, 8'h03);
      bg_mode = 1'b0;
      wr(CTRL, 8'h00);
      poll(CTRL, 8'hF0, 8'h80);
      chk({6'h00, bp_enable, timer_halt}, 8'h02);
      bp_match = 1'b1;
      @(negedge sys_clk);
      chk({7'h00, break_req}, 8'h01);
      bg_mode = 1'b1;
      wr(CTRL, 8'h00);
      poll(CTRL, 8'hF0, 8'h00);
      chk({6'h00, bp_enable, break_req}, 8'h00);
      bp_match = 1'b0;
      for (int c = 0; c < 16; c++) begin
         wr(CTRL, {4'h0, 4'(c)});
         @(negedge sys_clk);
         chk({4'h0, dbg_cmd}, exp_cmd(4'(c)));
      end
      bg_mode = 1'b0;
      sys_rst = 1'b1;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      spe_set = 1'b1;
      @(negedge sys_clk) spe_set = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk({6'h00, boot_valid, boot_rom}, 8'h03);
      conclude();
   end
endmodule // debug_control_and_flag_regs_bench
